// [hdl/atsp_pkg.sv]
// Package of constants for the trigger-skipping triangle PWM timer
// Notes on behaviour
// - The counter runs from a 160 MHz clock with a 1 ms carrier, starts at zero, turns at the period.
// - The counter counts up first from zero; its peak is a crest and its bottom a trough.
// - Each output has a start/stop level, toggles on its duty match, holds at cycle end, with dead time.
// - With request generation on, a trigger-compare match while counting up raises a request.
// - With trough skip linked, requests pass only while the three-bit skip counter is zero.
// - While that counter is nonzero, underflow interrupts and requests are suppressed.
// - Each valid request drives the request monitor output high.
// - Extended counter one counts crests and gates trigger requests to when it is zero.
// - Extended counter two counts troughs and blocks buffer transfers while nonzero.
// - When extended counter two is zero, the buffer moves into the trigger compare at the trough.
// - Extended counter two takes a programmed start value of 0 to 15 before counting begins.
package atsp_pkg;
   localparam int CNT_W = 16;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PERIOD = 8'h04;
   localparam logic [7:0] OFF_DUTY_A = 8'h08;
   localparam logic [7:0] OFF_DUTY_B = 8'h0C;
   localparam logic [7:0] OFF_TRIG_BUF = 8'h10;
   localparam logic [7:0] OFF_TRIG_CMP = 8'h14;
   localparam logic [7:0] OFF_SKIP = 8'h18;
   localparam logic [7:0] OFF_DEAD = 8'h1C;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_MASK = 8'h24;
   localparam logic [7:0] OFF_COUNT = 8'h28;
   // Control bit positions
   localparam int CTL_RUN = 0;
   localparam int CTL_REQ_EN = 1;
   localparam int CTL_LINK = 2;
   localparam int CTL_LVL_A = 3;
   localparam int CTL_LVL_B = 4;
   localparam int CTL_EXT_EN = 5;
   localparam int CTL_BUF_EN = 6;
   // Skip register field positions
   localparam int SK_CNT = 0;    // [2:0] trough skip count
   localparam int SK_E1 = 4;     // [6:4] ext counter one skip count
   localparam int SK_E2 = 8;     // [10:8] ext counter two skip count
   localparam int SK_E2_INIT = 12; // [15:12] ext counter two start value
   // Status bits
   localparam int ST_REQ = 0;
   localparam int ST_UNDER = 1;
   localparam int ST_CREST = 2;
   localparam int ST_W = 3;
   // Reset values
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [31:0] CTRL_RST = 32'h0000_0008;
   // Example timing: 160 MHz timer clock, 1 ms carrier
   localparam int TIMER_CLK_MHZ = 160;
   localparam int CARRIER_US = 1000;
   localparam int CARRIER_TICKS = TIMER_CLK_MHZ * CARRIER_US;
endpackage

// [hdl/atsp_skip_cnt.sv]
// Wrapping skip counter with programmable start value
`timescale 1ns/1ps
module atsp_skip_cnt #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic [W-1:0] init_val,
   input wire logic [W-1:0] skip_cnt,
   input wire logic step,
   // State
   output logic [W-1:0] value,
   output logic zero
);
   // Elaboration guard: wider skip counts are never needed
   if (W < 1 || W > 8) begin : w_check
      $error("atsp_skip_cnt: W out of range");
   end

   // Load start value, then step with wrap after the skip count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= '0;
      end else if (load) begin
         value <= init_val;
      end else if (step) begin
         value <= (value >= skip_cnt) ? '0 : W'(value + 1'b1);
      end
   end

   assign zero = (value == '0);
endmodule

// [hdl/atsp_pwm_out.sv]
// One PWM output pin with start level, match toggle and dead time
`timescale 1ns/1ps
module atsp_pwm_out #(
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic start_lvl,
   input wire logic match,
   input wire logic [DW-1:0] dead,
   // Output
   output logic pin
);
   logic raw_r;
   logic [DW-1:0] dly_r;

   // Elaboration guard on the dead-time counter width
   if (DW < 1 || DW > 16) begin : dw_check
      $error("atsp_pwm_out: DW out of range");
   end

   // Fixed level while stopped, toggle on duty match, hold otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_r <= 1'b0;
      end else if (!run) begin
         raw_r <= start_lvl;
      end else if (match) begin
         raw_r <= ~raw_r;
      end
   end

   // Edge away from the start level is delayed by dead time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_r <= '0;
         pin <= 1'b0;
      end else if (raw_r == start_lvl || !run) begin
         dly_r <= '0;
         pin <= raw_r;
      end else if (dly_r >= dead) begin
         pin <= raw_r;
      end else begin
         dly_r <= DW'(dly_r + 1'b1);
      end
   end
endmodule

// [hdl/atsp_timer.sv]
// Triangle PWM timer with skipped converter start requests
`timescale 1ns/1ps
module atsp_timer (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and events
   output logic pwm_out_a,
   output logic pwm_out_b,
   output logic request_monitor_out,
   output logic adc_request_event,
   output logic underflow_interrupt,
   output logic irq
);
   localparam int W = atsp_pkg::CNT_W;

   // Elaboration guard: the count read-back word packs exactly 16 count bits
   if (W != 16) begin : cnt_w_check
      $error("atsp_timer: count width must be 16");
   end

   logic [31:0] ctrl_r;
   logic [W-1:0] period_r, duty_a_r, duty_b_r, trig_buf_r, trig_cmp_r, cnt_r;
   logic [15:0] skip_r;
   logic [7:0] dead_r;
   logic [atsp_pkg::ST_W-1:0] status_r, mask_r;
   logic down_r, run_d_r, mon_r;
   logic run, crest, trough, wr, rd, start;
   logic [2:0] tr_val;
   logic tr_zero, e1_zero, e2_zero, trig_match, req_ok, valid_req;
   logic [2:0] e1_val;
   logic [3:0] e2_val;
   logic [atsp_pkg::ST_W-1:0] ev;

   assign run = ctrl_r[atsp_pkg::CTL_RUN];
   assign start = run && !run_d_r;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign pready = 1'b1;

   // Unmapped address answers with an error
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= atsp_pkg::OFF_COUNT) && (a[1:0] == 2'b00);
   endfunction

   assign pslverr = psel && penable && !mapped(paddr);

   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= atsp_pkg::CTRL_RST;
         period_r <= atsp_pkg::PERIOD_RST;
         duty_a_r <= '0;
         duty_b_r <= '0;
         trig_buf_r <= '0;
         skip_r <= '0;
         dead_r <= '0;
         mask_r <= '0;
      end else if (wr) begin
         unique case (paddr)
            atsp_pkg::OFF_CTRL: ctrl_r <= pwdata;
            atsp_pkg::OFF_PERIOD: period_r <= pwdata[W-1:0];
            atsp_pkg::OFF_DUTY_A: duty_a_r <= pwdata[W-1:0];
            atsp_pkg::OFF_DUTY_B: duty_b_r <= pwdata[W-1:0];
            atsp_pkg::OFF_TRIG_BUF: trig_buf_r <= pwdata[W-1:0];
            atsp_pkg::OFF_SKIP: skip_r <= pwdata[15:0];
            atsp_pkg::OFF_DEAD: dead_r <= pwdata[7:0];
            atsp_pkg::OFF_MASK: mask_r <= pwdata[atsp_pkg::ST_W-1:0];
            default: ;
         endcase
      end
   end

   // Read mux, registered for clean data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd && !penable) begin
         unique case (paddr)
            atsp_pkg::OFF_CTRL: prdata <= ctrl_r;
            atsp_pkg::OFF_PERIOD: prdata <= 32'(period_r);
            atsp_pkg::OFF_DUTY_A: prdata <= 32'(duty_a_r);
            atsp_pkg::OFF_DUTY_B: prdata <= 32'(duty_b_r);
            atsp_pkg::OFF_TRIG_BUF: prdata <= 32'(trig_buf_r);
            atsp_pkg::OFF_TRIG_CMP: prdata <= 32'(trig_cmp_r);
            atsp_pkg::OFF_SKIP: prdata <= {13'h0000, e2_val, e1_val, 1'b0, tr_val, skip_r[7:0]};
            atsp_pkg::OFF_DEAD: prdata <= {24'h000000, dead_r};
            atsp_pkg::OFF_STATUS: prdata <= 32'(status_r);
            atsp_pkg::OFF_MASK: prdata <= 32'(mask_r);
            atsp_pkg::OFF_COUNT: prdata <= {15'h0000, down_r, cnt_r};
            default: prdata <= '0;
         endcase
      end
   end

   // Triangle counter: starts at zero upward, turns at period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         down_r <= 1'b0;
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= run;
         if (!run) begin
            cnt_r <= '0;
            down_r <= 1'b0;
         end else if (!down_r) begin
            if (cnt_r >= period_r) begin
               down_r <= 1'b1;
               cnt_r <= W'(cnt_r - 1'b1);
            end else begin
               cnt_r <= W'(cnt_r + 1'b1);
            end
         end else if (cnt_r == '0) begin
            down_r <= 1'b0;
            cnt_r <= W'(cnt_r + 1'b1);
         end else begin
            cnt_r <= W'(cnt_r - 1'b1);
         end
      end
   end

   // Crest at the top turn, trough at the bottom turn
   assign crest = run && !down_r && (cnt_r >= period_r);
   assign trough = run && down_r && (cnt_r == '0);

   // Trough skip counter for the linked request gate
   atsp_skip_cnt #(.W(3)) u_tr (
      .pclk(pclk), .presetn(presetn), .load(start), .init_val(3'h0),
      .skip_cnt(skip_r[atsp_pkg::SK_CNT +: 3]), .step(trough),
      .value(tr_val), .zero(tr_zero));

   // Extended counter one counts crests
   atsp_skip_cnt #(.W(3)) u_e1 (
      .pclk(pclk), .presetn(presetn), .load(start), .init_val(3'h0),
      .skip_cnt(skip_r[atsp_pkg::SK_E1 +: 3]), .step(crest),
      .value(e1_val), .zero(e1_zero));

   // Extended counter two counts troughs, start value preloaded
   atsp_skip_cnt #(.W(4)) u_e2 (
      .pclk(pclk), .presetn(presetn), .load(start),
      .init_val(skip_r[atsp_pkg::SK_E2_INIT +: 4]),
      .skip_cnt({1'b0, skip_r[atsp_pkg::SK_E2 +: 3]}), .step(trough),
      .value(e2_val), .zero(e2_zero));

   // Buffer transfer at trough; with buffer skip enabled, only when counter two is zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_cmp_r <= '0;
      end else if (!run) begin
         trig_cmp_r <= trig_buf_r; // Preload so first carrier has a value
      end else if (trough && (!ctrl_r[atsp_pkg::CTL_BUF_EN] || e2_zero)) begin
         trig_cmp_r <= trig_buf_r;
      end
   end

   // Request gating: up-count match, then skip gates
   assign trig_match = run && !down_r && (cnt_r == trig_cmp_r);
   assign req_ok = (!ctrl_r[atsp_pkg::CTL_LINK] || tr_zero)
      && (!ctrl_r[atsp_pkg::CTL_EXT_EN] || e1_zero);
   assign valid_req = ctrl_r[atsp_pkg::CTL_REQ_EN] && trig_match && req_ok;

   // Event output is a single-cycle pulse toward the event fabric
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_request_event <= 1'b0;
         underflow_interrupt <= 1'b0;
      end else begin
         adc_request_event <= valid_req;
         underflow_interrupt <= trough && (!ctrl_r[atsp_pkg::CTL_LINK] || tr_zero);
      end
   end

   // Monitor goes high on a valid request, low at the crest
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_r <= 1'b0;
      end else if (valid_req) begin
         mon_r <= 1'b1;
      end else if (crest || !run) begin
         mon_r <= 1'b0;
      end
   end
   assign request_monitor_out = mon_r;

   // Sticky status; set wins over write-one clear
   assign ev = {crest, trough && (!ctrl_r[atsp_pkg::CTL_LINK] || tr_zero), valid_req};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~((wr && paddr == atsp_pkg::OFF_STATUS)
            ? pwdata[atsp_pkg::ST_W-1:0] : '0)) | ev;
      end
   end
   assign irq = |(status_r & mask_r);

   // Output pins; B's start level has its own control bit
   atsp_pwm_out #(.DW(8)) u_pa (
      .pclk(pclk), .presetn(presetn), .run(run),
      .start_lvl(ctrl_r[atsp_pkg::CTL_LVL_A]), .match(run && cnt_r == duty_a_r),
      .dead(dead_r), .pin(pwm_out_a));
   atsp_pwm_out #(.DW(8)) u_pb (
      .pclk(pclk), .presetn(presetn), .run(run),
      .start_lvl(ctrl_r[atsp_pkg::CTL_LVL_B]), .match(run && cnt_r == duty_b_r),
      .dead(dead_r), .pin(pwm_out_b));

   // Checks: request generation
   req_up_a: assert property (@(posedge pclk) disable iff (!presetn)
      valid_req |-> !down_r)
      else $error("request while counting down");
   req_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      valid_req |=> adc_request_event)
      else $error("request event missing");
   event_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      adc_request_event |=> !adc_request_event)
      else $error("request event longer than one cycle");

   // Checks: skip gates on requests, both closed and open
   link_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[atsp_pkg::CTL_LINK] && !tr_zero) |-> !valid_req)
      else $error("request passed nonzero skip");
   link_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[atsp_pkg::CTL_REQ_EN] && trig_match && tr_zero && !ctrl_r[atsp_pkg::CTL_EXT_EN])
      |-> valid_req)
      else $error("request lost with skip counter zero");
   ext_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[atsp_pkg::CTL_EXT_EN] && !e1_zero) |-> !valid_req)
      else $error("request passed ext counter");
   ext_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[atsp_pkg::CTL_REQ_EN] && trig_match && e1_zero && !ctrl_r[atsp_pkg::CTL_LINK])
      |-> valid_req)
      else $error("request lost with ext counter zero");

   // Checks: underflow pulses follow the trough skip
   uf_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trough && ctrl_r[atsp_pkg::CTL_LINK] && !tr_zero) |=> !underflow_interrupt)
      else $error("underflow not skipped");
   uf_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trough && tr_zero) |=> underflow_interrupt)
      else $error("underflow missing");

   // Checks: monitor level
   mon_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      valid_req |=> request_monitor_out)
      else $error("monitor not high");
   mon_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      (crest && !valid_req) |=> !request_monitor_out)
      else $error("monitor not low after crest");

   // Checks: skip counters load at start and wrap after their count
   skip_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trough && !start && tr_val >= skip_r[atsp_pkg::SK_CNT +: 3]) |=> tr_val == 3'h0)
      else $error("skip counter no wrap");
   e1_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (crest && !start && e1_val >= skip_r[atsp_pkg::SK_E1 +: 3]) |=> e1_val == 3'h0)
      else $error("ext counter one no wrap");
   e2_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trough && !start && e2_val >= {1'b0, skip_r[atsp_pkg::SK_E2 +: 3]}) |=> e2_val == 4'h0)
      else $error("ext counter two no wrap");
   skip_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> tr_val == 3'h0 && e1_val == 3'h0)
      else $error("skip counters not cleared at start");
   e2_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> e2_val == $past(skip_r[atsp_pkg::SK_E2_INIT +: 4]))
      else $error("ext counter two start value not loaded");

   // Checks: buffer transfer into the trigger compare
   buf_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      (run && ctrl_r[atsp_pkg::CTL_BUF_EN] && !e2_zero) |=> $stable(trig_cmp_r) || !run)
      else $error("buffer moved while skipped");
   buf_move_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trough && e2_zero) |=> trig_cmp_r == $past(trig_buf_r))
      else $error("buffer transfer missing");

   // Checks: triangle counter
   count_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      start |-> cnt_r == '0 && !down_r)
      else $error("count not from zero");
   count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      (run && !down_r && !crest) |=> cnt_r == $past(cnt_r) + 1'b1)
      else $error("count did not step up");
   crest_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
      crest |=> down_r)
      else $error("no turn at crest");
   trough_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
      trough |=> !down_r && cnt_r == W'(1))
      else $error("no turn at trough");

   // Checks: stop levels; the pin lags the setting by two flops
   pin_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !run [*4] |-> pwm_out_a == $past(ctrl_r[atsp_pkg::CTL_LVL_A], 2))
      else $error("stop level wrong on pin a");
   pin_stop_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      !run [*4] |-> pwm_out_b == $past(ctrl_r[atsp_pkg::CTL_LVL_B], 2))
      else $error("stop level wrong on pin b");
endmodule

// [tb/atsp_adc_model.sv]
// Converter side model: one scan per start event, with gap timing
`timescale 1ns/1ps
module atsp_adc_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Start event from the timer
   input wire logic start,
   // Scan bookkeeping
   output int scan_count,
   output int gap
);
   int stamp;
   int last;
   // Free cycle stamp for measuring event spacing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp <= 0;
      end else begin
         stamp <= stamp + 1;
      end
   end
   // Each start pulse begins exactly one single scan
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_count <= 0;
         gap <= 0;
         last <= 0;
      end else if (start === 1'b1) begin
         scan_count <= scan_count + 1;
         gap <= stamp - last;
         last <= stamp;
      end
   end
endmodule

// [tb/tb.sv]
// Self-checking bench for the trigger-skipping PWM timer
`timescale 1ns/1ps
module tb;
   localparam int P = 20;
   logic pclk, presetn, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, e, pa, pb, mon, ev, uf, irq;
   int failures, check_count, uf_n, scans, gap;
   atsp_timer atsp_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out_a(pa),
      .pwm_out_b(pb), .request_monitor_out(mon), .adc_request_event(ev),
      .underflow_interrupt(uf), .irq(irq));
   atsp_adc_model atsp_adc_model_i (.pclk(pclk), .presetn(presetn),
      .start(ev), .scan_count(scans), .gap(gap));
   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Underflow pulse tally
   always @(posedge pclk) begin
      if (uf === 1'b1) uf_n++;
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   // One APB transfer; waits for pready, takes data at that edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 100) failures++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(n, q, x);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Wait for two events; compare their spacing and underflow pulses between them
   task meas(input int xg, input int xu);
      int n0, u0, i;
      n0 = scans;
      for (i = 0; i < 4000 && scans < n0 + 1; i++) begin
         @(posedge pclk);
         #1;
      end
      chk("monitor", {31'h0, mon}, 32'h1);
      u0 = uf_n;
      for (i = 0; i < 4000 && scans < n0 + 2; i++) begin
         @(posedge pclk);
         #1;
      end
      chk("scan count", scans, n0 + 2);
      chk("gap", gap, xg);
      if (xu >= 0) chk("troughs", uf_n - u0, xu);
   endtask
   // Watchdog
   initial begin
      #400000;
      failures++;
      test_done();
   end
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      failures = 0;
      check_count = 0;
      uf_n = 0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl", atsp_pkg::OFF_CTRL, atsp_pkg::CTRL_RST);
      rdc("period", atsp_pkg::OFF_PERIOD, {16'h0, atsp_pkg::PERIOD_RST});
      chk("pin a", {31'h0, pa}, 32'h1);
      chk("pin b", {31'h0, pb}, 32'h0);
      rdc("unmapped", 8'h2C, 32'h0);
      chk("slverr", {31'h0, e}, 32'h1);
      wr(atsp_pkg::OFF_PERIOD, P);
      wr(atsp_pkg::OFF_TRIG_BUF, 32'h5);
      rdc("cmp idle", atsp_pkg::OFF_TRIG_CMP, 32'h5);
      wr(atsp_pkg::OFF_CTRL, 32'hB);
      meas(2 * P, 1);
      wr(atsp_pkg::OFF_CTRL, 32'h8);
      wr(atsp_pkg::OFF_SKIP, 32'h2);
      wr(atsp_pkg::OFF_CTRL, 32'hF);
      meas(6 * P, 1);
      wr(atsp_pkg::OFF_CTRL, 32'h8);
      wr(atsp_pkg::OFF_SKIP, 32'h20);
      wr(atsp_pkg::OFF_CTRL, 32'h2B);
      meas(6 * P, -1);
      wr(atsp_pkg::OFF_CTRL, 32'h8);
      wr(atsp_pkg::OFF_SKIP, 32'h300);
      wr(atsp_pkg::OFF_CTRL, 32'h4B);
      // First trough moves the buffer, the next three are skipped
      repeat (2 * P + 10) @(posedge pclk);
      wr(atsp_pkg::OFF_TRIG_BUF, 32'h9);
      repeat (2 * P) @(posedge pclk);
      rdc("cmp held", atsp_pkg::OFF_TRIG_CMP, 32'h5);
      repeat (6 * P) @(posedge pclk);
      rdc("cmp moved", atsp_pkg::OFF_TRIG_CMP, 32'h9);
      wr(atsp_pkg::OFF_CTRL, 32'h8);
      wr(atsp_pkg::OFF_MASK, 32'h1);
      @(negedge pclk);
      chk("irq on", {31'h0, irq}, 32'h1);
      wr(atsp_pkg::OFF_STATUS, 32'h7);
      rdc("status", atsp_pkg::OFF_STATUS, 32'h0);
      chk("irq off", {31'h0, irq}, 32'h0);
      test_done();
   end
endmodule
